//--- design/sss_defines.svh
// Register offsets, field positions, mode codes and counts of the serial port.
`ifndef SSS_DEFINES_SVH
`define SSS_DEFINES_SVH

`define SSS_OFF_CTRL      3'h0
`define SSS_OFF_STAT      3'h1
`define SSS_OFF_BUF       3'h2
`define SSS_OFF_ADDR      3'h3
`define SSS_OFF_IRQ       3'h4

`define SSS_CTRL_WRITE_COLLISION_FLAG     7
`define SSS_CTRL_OV       6
`define SSS_CTRL_EN       5
`define SSS_CTRL_CKP      4
`define SSS_STAT_SMP      7
`define SSS_STAT_CKE      6
`define SSS_STAT_STOP     4
`define SSS_STAT_START    3
`define SSS_STAT_BF       0
`define SSS_IRQ_FLAG      0
`define SSS_IRQ_IE        1
`define SSS_IRQ_SDOIN     2

`define SSS_REG_RST       8'h00

`define SSS_MODE_SPI_M4   4'h0
`define SSS_MODE_SPI_M16  4'h1
`define SSS_MODE_SPI_M64  4'h2
`define SSS_MODE_SPI_TMR  4'h3
`define SSS_MODE_SPI_SS   4'h4
`define SSS_MODE_SPI_NOSS 4'h5
`define SSS_MODE_I2C_S7   4'h6
`define SSS_MODE_I2C_S10  4'h7
`define SSS_MODE_I2C_MST  4'h8
`define SSS_MODE_I2C_FW   4'hB
`define SSS_MODE_I2C_S7I  4'hE
`define SSS_MODE_I2C_S10I 4'hF

`define SSS_HALF_DIV4     9'h002
`define SSS_HALF_DIV16    9'h008
`define SSS_HALF_DIV64    9'h020
`define SSS_LAST_BIT      4'h7
`define SSS_LAST_TOGGLE   5'h0F

`endif

//--- design/sss_pkg.sv
// Types and mode decoding shared by the serial port modules.
package sss_pkg;
  `include "sss_defines.svh"

  typedef enum logic {MS_IDLE, MS_RUN} sss_mst_e;
  typedef logic [7:0] sss_byte_t;

  function automatic logic sssIsSpiMaster(input logic [3:0] mode);
    sssIsSpiMaster = (mode <= `SSS_MODE_SPI_TMR);
  endfunction

  function automatic logic sssIsSpiSlave(input logic [3:0] mode);
    sssIsSpiSlave = (mode == `SSS_MODE_SPI_SS) || (mode == `SSS_MODE_SPI_NOSS);
  endfunction

  function automatic logic sssIsI2c(input logic [3:0] mode);
    sssIsI2c = (mode == `SSS_MODE_I2C_S7) || (mode == `SSS_MODE_I2C_S10) ||
               (mode == `SSS_MODE_I2C_MST) || (mode == `SSS_MODE_I2C_FW) ||
               (mode == `SSS_MODE_I2C_S7I) || (mode == `SSS_MODE_I2C_S10I);
  endfunction
endpackage

//--- design/sss_pin_sync.sv
// Three-stage pin synchroniser whose output follows once stages two and three agree.
`timescale 1ns/1ps
module sss_pin_sync
  import sss_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic pinIn,
  output logic      pinSync
);
  logic stage1_r;
  logic stage2_r;
  logic stage3_r;
  logic level_r;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      stage1_r <= 1'b0;
      stage2_r <= 1'b0;
      stage3_r <= 1'b0;
    end
    else
    begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      level_r <= 1'b0;
    else if (stage2_r == stage3_r)
      level_r <= stage3_r;
  end

  assign pinSync = level_r;
endmodule

//--- design/sss_clk_div.sv
// Half-period tick generator for the master serial clock.
`timescale 1ns/1ps
module sss_clk_div
  import sss_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       run,
  input  wire logic       useTimer,
  input  wire logic       timerTick,
  input  wire logic [8:0] halfPeriod,
  output logic            tick
);
  logic [8:0] count_r;
  logic       tick_r;

  // The count holds while run is low, so a frozen transfer resumes mid-bit.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      count_r <= 9'h000;
      tick_r  <= 1'b0;
    end
    else if (!run)
      tick_r <= 1'b0;
    else if (useTimer)
      tick_r <= timerTick;
    else if (count_r >= halfPeriod - 9'h001)
    begin
      count_r <= 9'h000;
      tick_r  <= 1'b1;
    end
    else
    begin
      count_r <= count_r + 9'h001;
      tick_r  <= 1'b0;
    end
  end

  assign tick = tick_r;
endmodule

//--- design/sss_port.sv
// Synchronous serial port: SPI master and slave with select, and I2C byte shifting.
//
// Summary of operation
// - Select sync only in slave-with-select mode.
// - Select low enables shifting and drives output.
// - Select high floats data output after the select sync delay.
// - Select high resets port in select mode.
// - Port reset zeroes the bit counter.
// - Output configured as input never transmits.
// - Master transfer freezes during sleep, resumes.
// - Slave shifting follows only external clock.
// - Eighth slave bit sets flag, may wake.
// - Master completion raises interrupt, may wake.
// - Device reset disables port, aborts transfer.
// - SPI modes map onto polarity and edge.
// - Status: two RW bits, six read-only.
// - Address register: own address or reload; only the I2C master reload is used.
// - I2C receive moves byte to buffer.
// - I2C buffer write loads shift register too.
// - Status bit seven selects slew control.
// - Status bit six enables SMBus thresholds.
// - I2C modes, addressing, start/stop interrupts; slave modes do no address match.
// - Mode field selects master divider or slave.
// - Polarity bit sets serial clock idle level.
`timescale 1ns/1ps
module sss_port
  import sss_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [2:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrEn,
  input  wire logic       regRdEn,
  output logic      [7:0] regRdData,
  input  wire logic       sleepMode,
  input  wire logic       timerTick,
  input  wire logic       sckIn,
  output logic            sckOut,
  output logic            sckOe,
  input  wire logic       sdiIn,
  output logic            sdoOut,
  output logic            sdoOe,
  output logic            sdaOut,
  output logic            sdaOe,
  input  wire logic       slaveSelectN,
  output logic            portIntFlag,
  output logic            wakeRequest,
  output logic            slewCtrlEn,
  output logic            smbusThreshEn
);
  logic       ctrlWcol_r;
  logic       ctrlOv_r;
  logic       ctrlEn_r;
  logic       ctrlCkp_r;
  logic [3:0] ctrlMode_r;
  logic       statSmp_r;
  logic       statCke_r;
  logic       statStop_r;
  logic       statStart_r;
  logic       statBf_r;
  sss_byte_t  bufData_r;
  sss_byte_t  addrReload_r;
  logic       intFlag_r;
  logic       intEnable_r;
  logic       sdoDirIn_r;
  sss_byte_t  shiftReg_r;
  logic [3:0] bitCnt_r;
  logic       lastSample_r;
  sss_mst_e   mstState_r;
  logic [4:0] toggleCnt_r;
  logic       sckLevel_r;
  logic       sckLevel_nxt;
  logic       i2cTx_r;
  logic       sckPrev_r;
  logic       sdiPrev_r;
  logic       sckOe_r;
  logic       sdoOe_r;
  logic       sdaOe_r;
  logic       wake_r;
  logic       slew_r;
  logic       smbus_r;
  sss_byte_t  rdData_r;

  logic       sckSync;
  logic       sdiSync;
  logic       ssSync;
  logic       divTick;
  logic [8:0] halfPeriod;
  logic       spiMaster;
  logic       spiSlave;
  logic       i2cOn;
  logic       i2cMaster;
  logic       anyMaster;
  logic       selectMode;
  logic       portReset;
  logic       slaveShiftOk;
  logic       ckpEff;
  logic       ckeEff;
  logic       mstRun;
  logic       masterToggle;
  logic       extEdge;
  logic       edgeAny;
  logic       prevLevel;
  logic       leadEdge;
  logic       trailEdge;
  logic       sampleEdge;
  logic       outEdge;
  logic       byteDone;
  logic       bufWrite;
  logic       bufRead;
  logic       busy;
  logic       wcolSet;
  logic       bufLoad;
  logic       rxStore;
  logic       ovSet;
  logic       startDet;
  logic       stopDet;
  logic       ssIntMode;
  logic       intSet;
  logic       ctrlWrite;
  logic       statWrite;
  logic       irqWrite;

  sss_pin_sync u_sck_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .pinIn   (sckIn),
    .pinSync (sckSync)
  );

  sss_pin_sync u_sdi_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .pinIn   (sdiIn),
    .pinSync (sdiSync)
  );

  sss_pin_sync u_ss_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .pinIn   (slaveSelectN),
    .pinSync (ssSync)
  );

  // Master bit clock: system clock by 4, 16 or 64, timer, or I2C reload.
  always_comb
  begin
    case (ctrlMode_r)
      `SSS_MODE_SPI_M4:  halfPeriod = `SSS_HALF_DIV4;
      `SSS_MODE_SPI_M16: halfPeriod = `SSS_HALF_DIV16;
      `SSS_MODE_SPI_M64: halfPeriod = `SSS_HALF_DIV64;
      `SSS_MODE_I2C_MST: halfPeriod = {1'b0, addrReload_r[6:0], 1'b0} + `SSS_HALF_DIV4;
      default:           halfPeriod = `SSS_HALF_DIV4;
    endcase
  end

  sss_clk_div u_clk_div (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .run        (mstRun && !sleepMode),
    .useTimer   (ctrlMode_r == `SSS_MODE_SPI_TMR),
    .timerTick  (timerTick),
    .halfPeriod (halfPeriod),
    .tick       (divTick)
  );

  assign spiMaster    = ctrlEn_r && sssIsSpiMaster(ctrlMode_r);
  assign spiSlave     = ctrlEn_r && sssIsSpiSlave(ctrlMode_r);
  assign i2cOn        = ctrlEn_r && sssIsI2c(ctrlMode_r);
  assign i2cMaster    = ctrlEn_r && (ctrlMode_r == `SSS_MODE_I2C_MST);
  assign anyMaster    = spiMaster || i2cMaster;
  assign selectMode   = ctrlEn_r && (ctrlMode_r == `SSS_MODE_SPI_SS);
  assign portReset    = !ctrlEn_r || (selectMode && ssSync);
  assign slaveShiftOk = spiSlave && (!selectMode || !ssSync);
  assign ckpEff       = i2cOn ? 1'b0 : ctrlCkp_r;
  assign ckeEff       = i2cOn ? 1'b1 : statCke_r;
  assign mstRun       = (mstState_r == MS_RUN);

  // Edges come from the divider in master modes (halted in sleep) or from the pin.
  assign masterToggle = divTick && mstRun && !sleepMode;
  assign extEdge      = (slaveShiftOk || (i2cOn && !i2cMaster)) && (sckSync != sckPrev_r);
  assign edgeAny      = masterToggle || extEdge;
  assign prevLevel    = masterToggle ? sckLevel_r : sckPrev_r;
  assign leadEdge     = edgeAny && (prevLevel == ckpEff);
  assign trailEdge    = edgeAny && (prevLevel != ckpEff);
  // Edge bit set samples on the leading edge, clear samples on the trailing edge.
  assign sampleEdge   = (ckeEff ? leadEdge : trailEdge) && !portReset;
  assign outEdge      = (ckeEff ? trailEdge : leadEdge) && !portReset;
  assign byteDone     = sampleEdge && (bitCnt_r == `SSS_LAST_BIT);

  assign bufWrite  = regWrEn && (regAddr == `SSS_OFF_BUF);
  assign bufRead   = regRdEn && (regAddr == `SSS_OFF_BUF);
  assign ctrlWrite = regWrEn && (regAddr == `SSS_OFF_CTRL);
  assign statWrite = regWrEn && (regAddr == `SSS_OFF_STAT);
  assign irqWrite  = regWrEn && (regAddr == `SSS_OFF_IRQ);
  assign busy      = mstRun || (bitCnt_r != 4'h0) || i2cTx_r;
  assign wcolSet   = bufWrite && ctrlEn_r && busy;
  assign bufLoad   = bufWrite && !wcolSet;
  assign rxStore   = byteDone && !i2cTx_r;
  assign ovSet     = rxStore && statBf_r && !bufRead;

  assign startDet  = i2cOn && sckSync && sckPrev_r && sdiPrev_r && !sdiSync;
  assign stopDet   = i2cOn && sckSync && sckPrev_r && !sdiPrev_r && sdiSync;
  assign ssIntMode = (ctrlMode_r == `SSS_MODE_I2C_S7I) || (ctrlMode_r == `SSS_MODE_I2C_S10I);
  assign intSet    = byteDone || (ssIntMode && (startDet || stopDet));

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      sckPrev_r <= 1'b0;
      sdiPrev_r <= 1'b0;
    end
    else
    begin
      sckPrev_r <= sckSync;
      sdiPrev_r <= sdiSync;
    end
  end

  // Control register; hardware-set flags win over a software write in the same cycle.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ctrlWcol_r <= 1'b0;
      ctrlOv_r   <= 1'b0;
      ctrlEn_r   <= 1'b0;
      ctrlCkp_r  <= 1'b0;
      ctrlMode_r <= `SSS_MODE_SPI_M4;
    end
    else
    begin
      if (wcolSet)
        ctrlWcol_r <= 1'b1;
      else if (ctrlWrite)
        ctrlWcol_r <= regWrData[`SSS_CTRL_WRITE_COLLISION_FLAG];
      if (ovSet)
        ctrlOv_r <= 1'b1;
      else if (ctrlWrite)
        ctrlOv_r <= regWrData[`SSS_CTRL_OV];
      if (ctrlWrite)
      begin
        ctrlEn_r   <= regWrData[`SSS_CTRL_EN];
        ctrlCkp_r  <= regWrData[`SSS_CTRL_CKP];
        ctrlMode_r <= regWrData[3:0];
      end
    end
  end

  // Status: only the two top bits are writable.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      statSmp_r <= 1'b0;
      statCke_r <= 1'b0;
    end
    else if (statWrite)
    begin
      statSmp_r <= regWrData[`SSS_STAT_SMP];
      statCke_r <= regWrData[`SSS_STAT_CKE];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset || !i2cOn)
    begin
      statStart_r <= 1'b0;
      statStop_r  <= 1'b0;
    end
    else if (startDet)
    begin
      statStart_r <= 1'b1;
      statStop_r  <= 1'b0;
    end
    else if (stopDet)
    begin
      statStart_r <= 1'b0;
      statStop_r  <= 1'b1;
    end
  end

  // Buffer full: set by an arriving byte or an I2C transmit load, cleared by a read.
  // A byte that completes in the cycle of a buffer read wins, so it is not lost unflagged.
  always_ff @(posedge sys_clk)
  begin
    if (reset || !ctrlEn_r)
      statBf_r <= 1'b0;
    else if (rxStore || (bufLoad && i2cOn))
      statBf_r <= 1'b1;
    else if (bufRead || (byteDone && i2cTx_r))
      statBf_r <= 1'b0;
  end

  // A byte arriving while the buffer is still full is dropped and flagged as overflow.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      bufData_r <= `SSS_REG_RST;
    else if (bufLoad)
      bufData_r <= regWrData;
    else if (rxStore && !ovSet)
      bufData_r <= {shiftReg_r[6:0], sdiSync};
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      addrReload_r <= `SSS_REG_RST;
    else if (regWrEn && (regAddr == `SSS_OFF_ADDR))
      addrReload_r <= regWrData;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      intFlag_r   <= 1'b0;
      intEnable_r <= 1'b0;
      sdoDirIn_r  <= 1'b0;
    end
    else
    begin
      if (intSet)
        intFlag_r <= 1'b1;
      else if (irqWrite)
        intFlag_r <= regWrData[`SSS_IRQ_FLAG];
      if (irqWrite)
      begin
        intEnable_r <= regWrData[`SSS_IRQ_IE];
        sdoDirIn_r  <= regWrData[`SSS_IRQ_SDOIN];
      end
    end
  end

  // Shift register: the out edge shifts in the bit caught at the previous sample.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      shiftReg_r <= `SSS_REG_RST;
    else if (bufLoad)
      shiftReg_r <= regWrData;
    else if (byteDone)
      shiftReg_r <= {shiftReg_r[6:0], sdiSync};
    else if (outEdge && (bitCnt_r != 4'h0))
      shiftReg_r <= {shiftReg_r[6:0], lastSample_r};
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset || portReset || startDet || byteDone)
      bitCnt_r <= 4'h0;
    else if (sampleEdge)
      bitCnt_r <= bitCnt_r + 4'h1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      lastSample_r <= 1'b0;
    else if (sampleEdge)
      lastSample_r <= sdiSync;
  end

  // Master sequencer: sixteen clock toggles per byte, started by a buffer write.
  always_ff @(posedge sys_clk)
  begin
    if (reset || portReset)
    begin
      mstState_r  <= MS_IDLE;
      toggleCnt_r <= 5'h00;
    end
    else
    begin
      case (mstState_r)
        MS_IDLE:
        begin
          toggleCnt_r <= 5'h00;
          if (bufLoad && anyMaster)
            mstState_r <= MS_RUN;
        end
        MS_RUN:
        begin
          if (masterToggle)
          begin
            toggleCnt_r <= toggleCnt_r + 5'h01;
            if (toggleCnt_r == `SSS_LAST_TOGGLE)
              mstState_r <= MS_IDLE;
          end
        end
        default:
          mstState_r <= MS_IDLE;
      endcase
    end
  end

  always_comb
  begin
    sckLevel_nxt = sckLevel_r;
    if (!mstRun)
      sckLevel_nxt = ckpEff;
    else if (masterToggle)
      sckLevel_nxt = !sckLevel_r;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      sckLevel_r <= 1'b0;
    else
      sckLevel_r <= sckLevel_nxt;
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset || portReset)
      i2cTx_r <= 1'b0;
    else if (bufLoad && i2cOn)
      i2cTx_r <= 1'b1;
    else if (byteDone)
      i2cTx_r <= 1'b0;
  end

  // Pin drivers.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      sckOe_r <= 1'b0;
      sdoOe_r <= 1'b0;
      sdaOe_r <= 1'b0;
    end
    else
    begin
      sckOe_r <= spiMaster || (i2cMaster && mstRun && !sckLevel_nxt);
      sdoOe_r <= !sdoDirIn_r && !portReset && (spiMaster || slaveShiftOk);
      sdaOe_r <= i2cOn && i2cTx_r && !shiftReg_r[7];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wake_r  <= 1'b0;
      slew_r  <= 1'b0;
      smbus_r <= 1'b0;
    end
    else
    begin
      wake_r  <= intFlag_r && intEnable_r;
      slew_r  <= i2cOn && !statSmp_r;
      smbus_r <= i2cOn && statCke_r;
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge sys_clk)
  begin
    if (reset || !regRdEn)
      rdData_r <= `SSS_REG_RST;
    else
    begin
      case (regAddr)
        `SSS_OFF_CTRL: rdData_r <= {ctrlWcol_r, ctrlOv_r, ctrlEn_r, ctrlCkp_r, ctrlMode_r};
        `SSS_OFF_STAT: rdData_r <= {statSmp_r, statCke_r, 1'b0, statStop_r, statStart_r,
                                    2'b00, statBf_r};
        `SSS_OFF_BUF:  rdData_r <= bufData_r;
        `SSS_OFF_ADDR: rdData_r <= addrReload_r;
        `SSS_OFF_IRQ:  rdData_r <= {5'h00, sdoDirIn_r, intEnable_r, intFlag_r};
        default:       rdData_r <= `SSS_REG_RST;
      endcase
    end
  end

  assign regRdData     = rdData_r;
  assign sckOut        = sckLevel_r;
  assign sckOe         = sckOe_r;
  assign sdoOut        = shiftReg_r[7];
  assign sdoOe         = sdoOe_r;
  assign sdaOut        = 1'b0;
  assign sdaOe         = sdaOe_r;
  assign portIntFlag   = intFlag_r;
  assign wakeRequest   = wake_r;
  assign slewCtrlEn    = slew_r;
  assign smbusThreshEn = smbus_r;
endmodule

//--- verification/sss_port_asserts.sv
// Concurrent checks on the ports of the serial port top module.
`timescale 1ns/1ps
module sss_port_asserts
  import sss_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic [2:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrEn,
  input wire logic       regRdEn,
  input wire logic [7:0] regRdData,
  input wire logic       sleepMode,
  input wire logic       slaveSelectN,
  input wire logic       sckOut,
  input wire logic       sckOe,
  input wire logic       sdoOe,
  input wire logic       portIntFlag,
  input wire logic       wakeRequest,
  input wire logic       slewCtrlEn,
  input wire logic       smbusThreshEn
);
  // Shadow copies of the software-written configuration, taken from the bus.
  logic [7:0] ctrlR;
  logic [7:0] statR;
  logic [7:0] irqR;
  logic       ssMode;
  logic       mstMode;
  logic       i2cMode;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      ctrlR <= 8'h00;
      statR <= 8'h00;
      irqR  <= 8'h00;
    end
    else if (regWrEn)
    begin
      if (regAddr == 3'h0) ctrlR <= regWrData;
      if (regAddr == 3'h1) statR <= regWrData;
      if (regAddr == 3'h4) irqR <= regWrData;
    end
  end

  assign ssMode  = ctrlR[5] && (ctrlR[3:0] == 4'h4);
  assign mstMode = ctrlR[5] && (ctrlR[3:0] <= 4'h3);
  assign i2cMode = ctrlR[3:0] inside {4'h6, 4'h7, 4'h8, 4'hB, 4'hE, 4'hF};

  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence ssHeld;
    (slaveSelectN && ssMode) [*7];
  endsequence

  sequence cfgSettled;
    (ctrlR[5] && $stable(ctrlR) && $stable(statR)) [*3];
  endsequence

  read_data_idle_a: assert property (!$past(regRdEn) |-> regRdData == 8'h00)
    else $error("read data not zero outside read slot");
  sdo_select_float_a: assert property (ssHeld |=> !sdoOe)
    else $error("data output driven with select high");
  sdo_dir_in_a: assert property (irqR[2] && $past(irqR[2]) |-> !sdoOe)
    else $error("data output driven while set as input");
  wake_on_flag_a: assert property ((portIntFlag && irqR[1]) [*3] |-> wakeRequest)
    else $error("wake missing with flag and enable");
  wake_cause_a: assert property ($rose(wakeRequest) |-> $past(portIntFlag))
    else $error("wake raised without flag");
  slew_select_a: assert property (cfgSettled |-> slewCtrlEn == (i2cMode && !statR[7]))
    else $error("slew control output wrong");
  smbus_select_a: assert property (cfgSettled |-> smbusThreshEn == (i2cMode && statR[6]))
    else $error("threshold select output wrong");
  fast_half_period_a: assert property ($changed(sckOut) && mstMode && ctrlR[3:0] == 4'h0 &&
    !sleepMode |=> $stable(sckOut))
    else $error("fastest clock toggled early");
  sleep_freeze_a: assert property ((sleepMode && mstMode) [*3] |-> $stable(sckOut))
    else $error("master clock moved in sleep");
  reset_quiet_a: assert property ($fell(reset) |-> !sckOe && !sdoOe && !portIntFlag)
    else $error("outputs active after reset");
endmodule

bind sss_port sss_port_asserts u_sss_port_asserts (.sys_clk, .reset, .regAddr, .regWrData,
  .regWrEn, .regRdEn, .regRdData, .sleepMode, .slaveSelectN, .sckOut, .sckOe, .sdoOe,
  .portIntFlag, .wakeRequest, .slewCtrlEn, .smbusThreshEn);

//--- verification/sss_spi_master_model.sv
// External SPI master model, bus mode 0,0, driving the slave pins of the port.
`timescale 1ns/1ps
module sss_spi_master_model
  import sss_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic sdoOut,
  output logic      sckIn,
  output logic      sdiIn,
  output logic      slaveSelectN
);
  localparam int HALF = 8;

  initial
  begin
    sckIn        = 1'b0;
    sdiIn        = 1'b0;
    slaveSelectN = 1'b1;
  end

  // Sends nBits MSB first and returns what the slave shifted out.
  task automatic xfer(input logic [7:0] tx, input int nBits, input logic useSs,
                      output logic [7:0] rx);
    rx = 8'h00;
    @(posedge sys_clk);
    slaveSelectN <= !useSs;
    repeat (HALF) @(posedge sys_clk);
    for (int i = 7; i > 7 - nBits; i--)
    begin
      sdiIn <= tx[i];
      repeat (HALF) @(posedge sys_clk);
      sckIn <= 1'b1;
      rx = {rx[6:0], sdoOut};
      repeat (HALF) @(posedge sys_clk);
      sckIn <= 1'b0;
    end
    repeat (HALF) @(posedge sys_clk);
    // A released line must not keep showing the last bit.
    sdiIn <= !sdiIn;
  endtask

  task automatic endFrame;
    @(posedge sys_clk);
    slaveSelectN <= 1'b1;
  endtask
endmodule

//--- verification/sss_port_tb.sv
// Self-checking testbench of the serial port.
`timescale 1ns/1ps
module sss_port_tb
  import sss_pkg::*;
;
  logic       sys_clk, reset, regWrEn, regRdEn, sleepMode, timerTick, prevSck;
  logic [2:0] regAddr;
  logic [7:0] regWrData, regRdData, rx;
  logic       sckIn, sdiIn, slaveSelectN, sckOut, sckOe, sdoOut, sdoOe, sdaOut, sdaOe;
  logic       portIntFlag, wakeRequest, slewCtrlEn, smbusThreshEn;
  int         nErrors, checksDone, toggles, firstAt, lastAt, cyc, snap;
  int         halfTab [4] = '{2, 8, 32, 5};

  sss_port u_sss_port (.sys_clk, .reset, .regAddr, .regWrData, .regWrEn, .regRdEn,
    .regRdData, .sleepMode, .timerTick, .sckIn, .sckOut, .sckOe, .sdiIn, .sdoOut, .sdoOe,
    .sdaOut, .sdaOe, .slaveSelectN, .portIntFlag, .wakeRequest, .slewCtrlEn, .smbusThreshEn);
  sss_spi_master_model u_sss_spi_master_model (.sys_clk, .sdoOut, .sckIn, .sdiIn,
    .slaveSelectN);

  always #50 sys_clk = ~sys_clk;

  // Timer pulses every fifth clock; serial clock edges are counted and time-stamped.
  always @(posedge sys_clk)
  begin
    cyc++;
    timerTick <= (cyc % 5 == 0);
    if (sckOut !== prevSck)
    begin
      if (toggles == 0) firstAt = cyc;
      lastAt = cyc;
      toggles++;
    end
    prevSck = sckOut;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1 chk(regRdData, e);
  endtask

  task automatic spi(input logic [7:0] tx, input int n, input logic useSs);
    u_sss_spi_master_model.xfer(tx, n, useSs, rx);
  endtask

  task automatic startMaster(input logic [7:0] ctrl);
    wr(3'h0, ctrl);
    wr(3'h4, 8'h00);
    @(negedge sys_clk);
    toggles = 0;
    wr(3'h2, 8'hC3);
  endtask

  task automatic closeOut;
    $display("checks %0d mismatches %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #(100 * 40000);
    nErrors++;
    closeOut();
  end

  initial
  begin
    {sys_clk, regWrEn, regRdEn, sleepMode, timerTick, prevSck} = '0;
    {regAddr, regWrData, cyc, toggles} = '0;
    reset = 1'b1;
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    for (int a = 0; a < 5; a++) rd(3'(a), 8'h00);
    wr(3'h5, 8'hFF);
    rd(3'h5, 8'h00);
    for (int m = 0; m < 4; m++)
    begin
      startMaster(8'(8'h20 + m));
      for (int k = 0; k < 2000 && toggles < 16; k++) @(posedge sys_clk);
      repeat (80) @(posedge sys_clk);
      chk(16'(toggles), 16'd16);
      chk(16'(lastAt - firstAt), 16'(15 * halfTab[m]));
      rd(3'h4, 8'h01);
      rd(3'h2, 8'h00);
    end
    startMaster(8'h20);
    repeat (6) @(posedge sys_clk);
    sleepMode <= 1'b1;
    repeat (3) @(negedge sys_clk);
    snap = toggles;
    repeat (30) @(negedge sys_clk);
    chk(16'(toggles), 16'(snap));
    @(posedge sys_clk);
    sleepMode <= 1'b0;
    repeat (60) @(negedge sys_clk);
    chk(16'(toggles), 16'd16);
    rd(3'h2, 8'h00);
    wr(3'h0, 8'h30);
    repeat (4) @(posedge sys_clk);
    chk(16'(sckOut), 16'd1);
    startMaster(8'h20);
    repeat (5) @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk(16'(sckOe), 16'd0);
    rd(3'h0, 8'h00);
    wr(3'h0, 8'h24);
    wr(3'h1, 8'h40);
    wr(3'h4, 8'h02);
    wr(3'h2, 8'h96);
    sleepMode <= 1'b1;
    spi(8'h3C, 8, 1'b1);
    chk(16'(rx), 16'h0096);
    repeat (10) @(posedge sys_clk);
    chk(16'(wakeRequest), 16'd1);
    sleepMode <= 1'b0;
    rd(3'h1, 8'h41);
    rd(3'h4, 8'h03);
    rd(3'h2, 8'h3C);
    u_sss_spi_master_model.endFrame();
    wr(3'h4, 8'h02);
    wr(3'h2, 8'hF0);
    spi(8'hFF, 4, 1'b1);
    chk(16'(rx), 16'h000F);
    chk(16'(sdoOe), 16'd1);
    u_sss_spi_master_model.endFrame();
    repeat (10) @(posedge sys_clk);
    chk(16'(sdoOe), 16'd0);
    spi(8'h5A, 8, 1'b1);
    repeat (10) @(posedge sys_clk);
    rd(3'h2, 8'h5A);
    u_sss_spi_master_model.endFrame();
    wr(3'h4, 8'h04);
    spi(8'hA5, 8, 1'b1);
    chk(16'(sdoOe), 16'd0);
    repeat (10) @(posedge sys_clk);
    rd(3'h2, 8'hA5);
    u_sss_spi_master_model.endFrame();
    wr(3'h0, 8'h25);
    spi(8'h69, 8, 1'b0);
    repeat (10) @(posedge sys_clk);
    rd(3'h2, 8'h69);
    wr(3'h0, 8'h26);
    wr(3'h1, 8'hFF);
    rd(3'h1, 8'hC0);
    repeat (4) @(posedge sys_clk);
    chk(16'({slewCtrlEn, smbusThreshEn}), 16'd1);
    wr(3'h1, 8'h40);
    repeat (4) @(posedge sys_clk);
    chk(16'({slewCtrlEn, smbusThreshEn}), 16'd3);
    wr(3'h3, 8'h7F);
    rd(3'h3, 8'h7F);
    wr(3'h2, 8'hA5);
    rd(3'h1, 8'h41);
    chk(16'({sdaOe, sdaOut, sdoOut}), 16'd1);
    wr(3'h2, 8'h00);
    rd(3'h0, 8'hA6);
    rd(3'h2, 8'hA5);
    closeOut();
  end
endmodule
